//--- verilog/sic_core.sv
// Purpose: irq coalescing and halt status of the stream-to-memory channel
// Assumes: APB master, channel events synchronous to SYS_CLK
// Notes:   zero-wait-state APB slave, PSLVERR on unmapped addresses
// Notes on behaviour
// - 8-bit threshold in control 23:16, reset 01h; countdown raises irq
// - threshold writes of 00h are ignored, previous value kept
// - 8-bit gap timeout in control 31:24, reset 00h; expiry raises irq
// - timer starts on packet end, stops and clears on new packet or timeout
// - timeout value zero never produces a timer interrupt
// - countdown and timer work only with descriptor chaining built in
// - status 34h bit 0 reads halted, 1 after reset, read only
// - chaining mode: halted after stop and movers plus descriptors idle
// - direct mode: halted after stop and data movement idle
// - halted may lag the stop bit; software polls it
// - chaining mode: tail pointer writes ignored while halted
// - direct mode: length writes start nothing while halted
// - completion irq flag set only if control bit 12 set at countdown hit; output gated by 38h bit 12
// - timer irq flag set only if control bit 13 set at expiry; output gated by 38h bit 13
`timescale 1ns/1ps
module sic_core
    import sic_pkg::*;
#(
    parameter bit SG_INCLUDED = 1'b1
) (
    input  wire logic                  SYS_CLK,
    input  wire logic                  RST_N,
    input  wire sic_pkg::sic_apb_req_t APB_REQ,
    output logic [31:0]                PRDATA,
    output logic                       PREADY,
    output logic                       PSLVERR,
    input  wire sic_pkg::sic_chan_in_t CHAN_IN,
    output logic                       RUN_STOP,
    output logic                       HALTED,
    output logic                       START_XFER,
    output logic                       IRQ
);
    import sic_pkg::*;

    sic_state_t s_ff;
    sic_state_t nxt_s;

    logic       acc;
    logic       wr;
    logic       mapped;
    logic       halted;
    logic       movers_idle;
    logic       cnt_hit;
    logic       tick;
    logic       tmr_exp;
    logic [1:0] ev_set;
    logic [1:0] ev_clr;

    function automatic logic hit(input logic [7:0] a, input logic [7:0] o);
        return a == o;
    endfunction

    assign acc    = APB_REQ.psel && APB_REQ.penable;
    assign wr     = acc && APB_REQ.pwrite;
    assign mapped = hit(APB_REQ.paddr, CTRL_OFS) ||
                    hit(APB_REQ.paddr, STAT_OFS) ||
                    hit(APB_REQ.paddr, IMASK_OFS) ||
                    hit(APB_REQ.paddr, TAIL_OFS) ||
                    hit(APB_REQ.paddr, LEN_OFS);
    assign halted = (s_ff.run == SIC_HALT);
    assign movers_idle = SG_INCLUDED
                       ? !(CHAN_IN.mover_busy || CHAN_IN.desc_busy)
                       : !CHAN_IN.mover_busy;
    assign cnt_hit = SG_INCLUDED && CHAN_IN.completion_event &&
                     s_ff.cnt == THR_RST;
    assign tick    = s_ff.pre == TICK_LAST;
    assign tmr_exp = SG_INCLUDED && s_ff.tmr_on && tick &&
                     s_ff.tmo != TMO_RST && s_ff.tmr == s_ff.tmo - 8'h01;
    assign ev_set = {tmr_exp && s_ff.tien, cnt_hit && s_ff.cien};
    assign ev_clr = (wr && hit(APB_REQ.paddr, STAT_OFS))
                  ? {APB_REQ.pwdata[TEV_BIT], APB_REQ.pwdata[CEV_BIT]}
                  : 2'b00;

    always_comb begin
        nxt_s = s_ff;
        nxt_s.start_pulse = 1'b0;
        nxt_s.pre = tick ? 16'h0000 : s_ff.pre + 16'h0001;
        if (wr && hit(APB_REQ.paddr, CTRL_OFS)) begin
            nxt_s.run_stop_control = APB_REQ.pwdata[RUN_BIT];
            nxt_s.cien = APB_REQ.pwdata[CIEN_BIT];
            nxt_s.tien = APB_REQ.pwdata[TIEN_BIT];
            nxt_s.tmo  = APB_REQ.pwdata[TMO_LSB +: 8];
            if (APB_REQ.pwdata[THR_LSB +: 8] != THR_ZERO) begin
                nxt_s.thr = APB_REQ.pwdata[THR_LSB +: 8];
                nxt_s.cnt = APB_REQ.pwdata[THR_LSB +: 8];
            end
        end
        if (wr && hit(APB_REQ.paddr, IMASK_OFS)) begin
            nxt_s.msk = {APB_REQ.pwdata[TEV_BIT], APB_REQ.pwdata[CEV_BIT]};
        end
        if (wr && !halted && s_ff.run_stop_control &&
            hit(APB_REQ.paddr, SG_INCLUDED ? TAIL_OFS : LEN_OFS)) begin
            nxt_s.start_pulse = 1'b1;
        end
        // countdown
        if (SG_INCLUDED && CHAN_IN.completion_event) begin
            nxt_s.cnt = cnt_hit ? s_ff.thr : s_ff.cnt - 8'h01;
        end
        // gap timer
        if (CHAN_IN.packet_start || tmr_exp) begin
            nxt_s.tmr    = 8'h00;
            nxt_s.tmr_on = 1'b0;
        end else if (CHAN_IN.packet_end) begin
            nxt_s.tmr    = 8'h00;
            nxt_s.tmr_on = 1'b1;
        end else if (s_ff.tmr_on && tick) begin
            nxt_s.tmr = s_ff.tmr + 8'h01;
        end
        // set wins over clear
        nxt_s.evt = (s_ff.evt & ~ev_clr) | ev_set;
        // run/stop to halted, may lag
        unique case (s_ff.run)
            SIC_RUN: begin
                if (!s_ff.run_stop_control) begin
                    nxt_s.run = SIC_DRAIN;
                end
            end
            SIC_DRAIN: begin
                if (s_ff.run_stop_control) begin
                    nxt_s.run = SIC_RUN;
                end else if (movers_idle) begin
                    nxt_s.run = SIC_HALT;
                end
            end
            SIC_HALT: begin
                if (s_ff.run_stop_control) begin
                    nxt_s.run = SIC_RUN;
                end
            end
            default: nxt_s.run = SIC_HALT;
        endcase
        nxt_s.prdata = 32'h0000_0000;
        if (APB_REQ.psel && !APB_REQ.penable && !APB_REQ.pwrite) begin
            if (hit(APB_REQ.paddr, CTRL_OFS)) begin
                nxt_s.prdata[RUN_BIT]        = s_ff.run_stop_control;
                nxt_s.prdata[CIEN_BIT]       = s_ff.cien;
                nxt_s.prdata[TIEN_BIT]       = s_ff.tien;
                nxt_s.prdata[THR_LSB +: 8]   = s_ff.thr;
                nxt_s.prdata[TMO_LSB +: 8]   = s_ff.tmo;
            end else if (hit(APB_REQ.paddr, STAT_OFS)) begin
                nxt_s.prdata[HALT_BIT]       = halted;
                nxt_s.prdata[SG_BIT]         = SG_INCLUDED;
                nxt_s.prdata[CEV_BIT]        = s_ff.evt[0];
                nxt_s.prdata[TEV_BIT]        = s_ff.evt[1];
                nxt_s.prdata[THR_LSB +: 8]   = s_ff.cnt;
                nxt_s.prdata[TMO_LSB +: 8]   = s_ff.tmr;
            end else if (hit(APB_REQ.paddr, IMASK_OFS)) begin
                nxt_s.prdata[CEV_BIT]        = s_ff.msk[0];
                nxt_s.prdata[TEV_BIT]        = s_ff.msk[1];
            end
        end else if (acc) begin
            nxt_s.prdata = s_ff.prdata;
        end
    end

    always_ff @(posedge SYS_CLK or negedge RST_N) begin
        if (!RST_N) begin
            s_ff                  <= '0;
            s_ff.run              <= SIC_HALT;
            s_ff.thr              <= THR_RST;
            s_ff.cnt              <= THR_RST;
            s_ff.tmo              <= TMO_RST;
            s_ff.msk              <= 2'b11;
        end else begin
            s_ff <= nxt_s;
        end
    end

    assign PRDATA     = s_ff.prdata;
    assign PREADY     = 1'b1;
    assign PSLVERR    = acc && !mapped;
    assign RUN_STOP   = s_ff.run_stop_control;
    assign HALTED     = halted;
    assign START_XFER = s_ff.start_pulse;
    assign IRQ        = |(s_ff.evt & s_ff.msk);

    // assertions
    a_halt_after_reset: assert property (@(posedge SYS_CLK)
        $rose(RST_N) |-> HALTED)
        else $error("halted not set after reset");
    a_halt_needs_stop: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
        $rose(HALTED) |-> $past(!RUN_STOP && movers_idle))
        else $error("halted set while running or busy");
    a_halt_direct: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
        $rose(HALTED) |-> $past(!CHAN_IN.mover_busy))
        else $error("halted set with data moving");
    a_halt_lag: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
        $fell(RUN_STOP) |-> !HALTED ##1 !HALTED)
        else $error("halted set at stop instant");
    a_no_start_halt: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
        START_XFER |-> $past(!halted))
        else $error("transfer started while halted");
    a_len_no_start: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
        START_XFER |-> $past(s_ff.run_stop_control))
        else $error("start with run bit clear");
    a_thr_nonzero: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
        s_ff.thr != THR_ZERO)
        else $error("threshold became zero");
    a_cnt_reload: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
        cnt_hit |=> s_ff.cnt == $past(s_ff.thr))
        else $error("countdown did not reload");
    a_cev_gated: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
        $rose(s_ff.evt[0]) |-> $past(s_ff.cien))
        else $error("completion event set while disabled");
    a_tev_gated: assert property (@(posedge SYS_CLK)
        disable iff (!RST_N)
        $rose(s_ff.evt[1]) |-> $past(s_ff.tien && s_ff.tmo != TMO_RST))
        else $error("timer event set while disabled");
    a_tmr_restart: assert property (@(posedge SYS_CLK)
        disable iff (!RST_N)
        CHAN_IN.packet_start |=> !s_ff.tmr_on && s_ff.tmr == 8'h00)
        else $error("timer not cleared on packet");
    c_irq_cnt: cover property (@(posedge SYS_CLK) cnt_hit && s_ff.cien);
    c_irq_tmr: cover property (@(posedge SYS_CLK) tmr_exp);
    c_halt:    cover property (@(posedge SYS_CLK) $rose(HALTED));
    c_start:   cover property (@(posedge SYS_CLK) START_XFER);
    c_tmr_restart: cover property (@(posedge SYS_CLK)
        s_ff.tmr_on && CHAN_IN.packet_start);

    // control write strobe, only used by the properties below
    logic ctrl_wr;
    assign ctrl_wr = wr && hit(APB_REQ.paddr, CTRL_OFS);

    // control register fields
    a_fld_reset: assert property (@(posedge SYS_CLK)
        $rose(RST_N) |-> s_ff.thr == THR_RST && s_ff.tmo == TMO_RST)
        else $error("control fields wrong after reset");
    a_thr_zero_kept: assert property (@(posedge SYS_CLK)
        disable iff (!RST_N)
        ctrl_wr && APB_REQ.pwdata[THR_LSB +: 8] == THR_ZERO
        |=> s_ff.thr == $past(s_ff.thr))
        else $error("zero threshold write took effect");
    a_thr_written: assert property (@(posedge SYS_CLK)
        disable iff (!RST_N)
        ctrl_wr && APB_REQ.pwdata[THR_LSB +: 8] != THR_ZERO
        |=> s_ff.thr == $past(APB_REQ.pwdata[THR_LSB +: 8]))
        else $error("threshold write lost");
    a_tmo_written: assert property (@(posedge SYS_CLK)
        disable iff (!RST_N)
        ctrl_wr |=> s_ff.tmo == $past(APB_REQ.pwdata[TMO_LSB +: 8]))
        else $error("timeout write lost");
    a_cien_written: assert property (@(posedge SYS_CLK)
        disable iff (!RST_N)
        ctrl_wr |=> s_ff.cien == $past(APB_REQ.pwdata[CIEN_BIT]))
        else $error("completion enable write lost");
    a_tien_written: assert property (@(posedge SYS_CLK)
        disable iff (!RST_N)
        ctrl_wr |=> s_ff.tien == $past(APB_REQ.pwdata[TIEN_BIT]))
        else $error("timer enable write lost");
    a_run_written: assert property (@(posedge SYS_CLK)
        disable iff (!RST_N)
        ctrl_wr |=> RUN_STOP == $past(APB_REQ.pwdata[RUN_BIT]))
        else $error("run bit write lost");

    // completion countdown
    a_cnt_decr: assert property (@(posedge SYS_CLK)
        disable iff (!RST_N)
        SG_INCLUDED && CHAN_IN.completion_event && !cnt_hit
        |=> s_ff.cnt == $past(s_ff.cnt) - 8'h01)
        else $error("countdown did not decrement");
    a_cev_set: assert property (@(posedge SYS_CLK)
        disable iff (!RST_N)
        cnt_hit && s_ff.cien |=> s_ff.evt[0])
        else $error("completion event not flagged");
    a_ev_clear: assert property (@(posedge SYS_CLK)
        disable iff (!RST_N)
        s_ff.evt[0] && ev_clr[0] && !ev_set[0] |=> !s_ff.evt[0])
        else $error("completion flag not cleared");
    a_sg_off_quiet: assert property (@(posedge SYS_CLK)
        disable iff (!RST_N)
        !SG_INCLUDED |-> !cnt_hit && !tmr_exp)
        else $error("coalescing active in direct mode");

    // packet gap timer
    a_tmo_zero_quiet: assert property (@(posedge SYS_CLK)
        disable iff (!RST_N)
        s_ff.tmo == TMO_RST |-> !tmr_exp)
        else $error("timer expired with zero timeout");
    a_tmr_start: assert property (@(posedge SYS_CLK)
        disable iff (!RST_N)
        CHAN_IN.packet_end && !CHAN_IN.packet_start && !tmr_exp
        |=> s_ff.tmr_on && s_ff.tmr == 8'h00)
        else $error("timer not started at packet end");
    a_tmr_stop: assert property (@(posedge SYS_CLK)
        disable iff (!RST_N)
        tmr_exp |=> !s_ff.tmr_on)
        else $error("timer still running after timeout");
    a_tmr_idle: assert property (@(posedge SYS_CLK)
        disable iff (!RST_N)
        !s_ff.tmr_on && !CHAN_IN.packet_end |=> !s_ff.tmr_on)
        else $error("timer started without packet end");
    a_tmr_hold: assert property (@(posedge SYS_CLK)
        disable iff (!RST_N)
        !tick && !CHAN_IN.packet_start && !CHAN_IN.packet_end
        |=> s_ff.tmr == $past(s_ff.tmr))
        else $error("timer moved between ticks");
    a_tick_wrap: assert property (@(posedge SYS_CLK)
        disable iff (!RST_N)
        tick |=> s_ff.pre == 16'h0000)
        else $error("prescaler did not wrap");
    a_tev_set: assert property (@(posedge SYS_CLK)
        disable iff (!RST_N)
        tmr_exp && s_ff.tien |=> s_ff.evt[1])
        else $error("timer event not flagged");

    // halted flag and transfer starts
    a_halt_stays: assert property (@(posedge SYS_CLK)
        disable iff (!RST_N)
        HALTED && !RUN_STOP |=> HALTED)
        else $error("halted dropped while stopped");
    a_halt_busy: assert property (@(posedge SYS_CLK)
        disable iff (!RST_N)
        !movers_idle && !HALTED |=> !HALTED)
        else $error("halted while channel busy");
    a_run_leaves: assert property (@(posedge SYS_CLK)
        disable iff (!RST_N)
        HALTED && RUN_STOP |=> !HALTED)
        else $error("halted kept after run set");
    a_start_on_wr: assert property (@(posedge SYS_CLK)
        disable iff (!RST_N)
        START_XFER |-> $past(wr))
        else $error("start without a register write");
endmodule

//--- shared/sic_pkg.sv
// Purpose: constants and types for the stream channel coalesce/halt block
// Assumes: 32-bit APB register access, 40 MHz system clock
// Notes:   offsets are byte addresses
package sic_pkg;
    localparam logic [7:0]  CTRL_OFS      = 8'h30;
    localparam logic [7:0]  STAT_OFS      = 8'h34;
    localparam logic [7:0]  IMASK_OFS     = 8'h38;
    localparam logic [7:0]  TAIL_OFS      = 8'h40;
    localparam logic [7:0]  LEN_OFS       = 8'h58;
    localparam int          RUN_BIT       = 0;
    localparam int          CIEN_BIT      = 12;
    localparam int          TIEN_BIT      = 13;
    localparam int          THR_LSB       = 16;
    localparam int          TMO_LSB       = 24;
    localparam int          HALT_BIT      = 0;
    localparam int          SG_BIT        = 3;
    localparam int          CEV_BIT       = 12;
    localparam int          TEV_BIT       = 13;
    localparam logic [7:0]  THR_RST       = 8'h01;
    localparam logic [7:0]  TMO_RST       = 8'h00;
    localparam logic [7:0]  THR_ZERO      = 8'h00;
    localparam logic [31:0] CTRL_WMASK    = 32'hFFFF_3001;
    localparam logic [31:0] EV_MASK       = 32'h0000_3000;
    // one delay unit of the gap timer, in ns
    localparam int          TICK_NS       = 1000;
    localparam int          CLK_NS        = 25;
    localparam int          TICK_CYC      = TICK_NS / CLK_NS;
    localparam logic [15:0] TICK_LAST     = 16'(TICK_CYC - 1);

    typedef enum logic [1:0] {
        SIC_RUN   = 2'b00,
        SIC_DRAIN = 2'b01,
        SIC_HALT  = 2'b10
    } sic_run_t;

    typedef struct packed {
        logic        psel;
        logic        penable;
        logic        pwrite;
        logic [7:0]  paddr;
        logic [31:0] pwdata;
    } sic_apb_req_t;

    typedef struct packed {
        logic        completion_event;
        logic        packet_start;
        logic        packet_end;
        logic        mover_busy;
        logic        desc_busy;
    } sic_chan_in_t;

    typedef struct packed {
        sic_run_t    run;
        logic        run_stop_control;
        logic        cien;
        logic        tien;
        logic [7:0]  thr;
        logic [7:0]  tmo;
        logic [7:0]  cnt;
        logic        tmr_on;
        logic [7:0]  tmr;
        logic [15:0] pre;
        logic [1:0]  evt;
        logic [1:0]  msk;
        logic [31:0] prdata;
        logic        start_pulse;
    } sic_state_t;
endpackage

//--- bench/sic_bench.sv
// Purpose: self-checking bench of the coalesce and halt status block
// Assumes: zero-wait APB slave, chaining mode built in
// Notes:   gap timer tick is 40 clocks at 25 ns
`timescale 1ns/1ps
module stream_to_memory_channel_irq_coalesce_and_halt_status_bench;
    import sic_pkg::*;
    logic         SYS_CLK = 1'b0;
    logic         RST_N   = 1'b0;
    sic_apb_req_t req     = '0;
    sic_chan_in_t chan    = '0;
    logic [31:0]  PRDATA;
    logic         PREADY, PSLVERR, RUN_STOP, HALTED, START_XFER, IRQ;
    logic [31:0]  d;
    logic         err;
    int           fail_count = 0;
    int           checked    = 0;
    int           starts     = 0;

    always #12.5 SYS_CLK = ~SYS_CLK;
    always @(posedge SYS_CLK) if (START_XFER === 1'b1) starts++;

    sic_core i_dut (
        .SYS_CLK    (SYS_CLK),
        .RST_N      (RST_N),
        .APB_REQ    (req),
        .PRDATA     (PRDATA),
        .PREADY     (PREADY),
        .PSLVERR    (PSLVERR),
        .CHAN_IN    (chan),
        .RUN_STOP   (RUN_STOP),
        .HALTED     (HALTED),
        .START_XFER (START_XFER),
        .IRQ        (IRQ)
    );

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            fail_count++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic chk1(input logic got, input logic exp);
        check({31'h0, got}, {31'h0, exp});
    endtask

    // setup, then access held until pready is seen at a rising edge
    task automatic apb(input logic wr, input logic [7:0] a,
                       input logic [31:0] wd);
        int n;
        n = 0;
        @(posedge SYS_CLK);
        req <= '{psel: 1'b1, penable: 1'b0, pwrite: wr, paddr: a,
                 pwdata: wd};
        @(posedge SYS_CLK);
        req.penable <= 1'b1;
        do begin
            @(posedge SYS_CLK);
            n++;
        end while (PREADY !== 1'b1 && n < 50);
        d   = PRDATA;
        err = PSLVERR;
        if (PREADY !== 1'b1) fail_count++;
        req <= '0;
        // return where outputs of the access edge have settled
        @(negedge SYS_CLK);
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] m,
                      input logic [31:0] e);
        apb(1'b0, a, 32'h0);
        check(d & m, e);
    endtask

    task automatic pulse(input int k, input int cnt);
        repeat (cnt) begin
            @(posedge SYS_CLK);
            if (k == 0) chan.completion_event <= 1'b1;
            if (k == 1) chan.packet_end <= 1'b1;
            if (k == 2) chan.packet_start <= 1'b1;
            @(posedge SYS_CLK);
            chan.completion_event <= 1'b0;
            chan.packet_end       <= 1'b0;
            chan.packet_start     <= 1'b0;
        end
        repeat (2) @(posedge SYS_CLK);
    endtask

    task automatic wait_sig(input bit irq_sel, input logic e, input int lim);
        for (int n = 0; n < lim; n++) begin
            @(posedge SYS_CLK);
            if ((irq_sel ? IRQ : HALTED) === e) break;
        end
        chk1(irq_sel ? IRQ : HALTED, e);
    endtask

    task automatic report_and_stop;
        $display("checked %0d fail_count %0d", checked, fail_count);
        if (fail_count == 0 && checked > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask

    initial begin
        #(25 * 20000);
        fail_count++;
        report_and_stop();
    end

    initial begin
        repeat (10) @(posedge SYS_CLK);
        RST_N <= 1'b1;
        rd(CTRL_OFS, CTRL_WMASK, 32'h0001_0000);
        rd(STAT_OFS, 32'h0000_3009, 32'h0000_0009);
        rd(IMASK_OFS, EV_MASK, EV_MASK);
        apb(1'b1, CTRL_OFS, 32'h0000_1000);
        rd(CTRL_OFS, CTRL_WMASK, 32'h0001_1000);
        apb(1'b1, CTRL_OFS, 32'h0003_1000);
        pulse(0, 2);
        chk1(IRQ, 1'b0);
        pulse(0, 1);
        chk1(IRQ, 1'b1);
        rd(STAT_OFS, EV_MASK, 32'h0000_1000);
        apb(1'b1, IMASK_OFS, 32'h0);
        chk1(IRQ, 1'b0);
        apb(1'b1, IMASK_OFS, EV_MASK);
        apb(1'b1, STAT_OFS, 32'h0000_1000);
        chk1(IRQ, 1'b0);
        pulse(0, 2);
        chk1(IRQ, 1'b0);
        pulse(0, 1);
        chk1(IRQ, 1'b1);
        apb(1'b1, STAT_OFS, EV_MASK);
        apb(1'b1, CTRL_OFS, 32'h0003_0000);
        pulse(0, 3);
        chk1(IRQ, 1'b0);
        apb(1'b1, CTRL_OFS, 32'h0201_2000);
        pulse(1, 1);
        repeat (33) @(posedge SYS_CLK);
        chk1(IRQ, 1'b0);
        wait_sig(1'b1, 1'b1, 60);
        rd(STAT_OFS, EV_MASK, 32'h0000_2000);
        apb(1'b1, STAT_OFS, EV_MASK);
        pulse(1, 1);
        repeat (30) @(posedge SYS_CLK);
        pulse(2, 1);
        repeat (100) @(posedge SYS_CLK);
        chk1(IRQ, 1'b0);
        apb(1'b1, CTRL_OFS, 32'h0201_0000);
        pulse(1, 1);
        repeat (120) @(posedge SYS_CLK);
        chk1(IRQ, 1'b0);
        apb(1'b1, CTRL_OFS, 32'h0001_2000);
        pulse(1, 1);
        repeat (120) @(posedge SYS_CLK);
        chk1(IRQ, 1'b0);
        apb(1'b1, CTRL_OFS, 32'h0001_0001);
        wait_sig(1'b0, 1'b0, 5);
        apb(1'b1, TAIL_OFS, 32'h0000_1000);
        repeat (2) @(posedge SYS_CLK);
        check(starts, 1);
        chan.mover_busy <= 1'b1;
        apb(1'b1, CTRL_OFS, 32'h0001_0000);
        repeat (10) @(posedge SYS_CLK);
        chk1(HALTED, 1'b0);
        chan.mover_busy <= 1'b0;
        chan.desc_busy  <= 1'b1;
        repeat (10) @(posedge SYS_CLK);
        chk1(HALTED, 1'b0);
        chan.desc_busy <= 1'b0;
        wait_sig(1'b0, 1'b1, 10);
        apb(1'b1, TAIL_OFS, 32'h0000_2000);
        repeat (2) @(posedge SYS_CLK);
        check(starts, 1);
        apb(1'b1, STAT_OFS, 32'h0);
        rd(STAT_OFS, 32'h1, 32'h1);
        rd(8'h7C, 32'hFFFF_FFFF, 32'h0);
        chk1(err, 1'b1);
        report_and_stop();
    end
endmodule
